/* File: shared/slb_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SLB_MAP_SVH
`define SLB_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLB_OFS_CTRL      8'h00
`define SLB_OFS_STATUS    8'h04
`define SLB_OFS_MASK      8'h08
`define SLB_OFS_STATE     8'h0c
`define SLB_OFS_GAP       8'h10
`define SLB_OFS_ERRCNT    8'h14

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SLB_CTRL_BURST    0
`define SLB_CTRL_ADVCLK   1
`define SLB_CTRL_ECC      2
`define SLB_CTRL_INJ1     3
`define SLB_CTRL_INJ2     4
`define SLB_CTRL_RST_VAL  5'h00

// ----------------------------------------------------------------
// Error and status fields
// ----------------------------------------------------------------
`define SLB_ERR_OVF       0
`define SLB_ERR_FIXED     1
`define SLB_ERR_FATAL     2
`define SLB_ERR_GAP       3
`define SLB_GAP_RST_VAL   16'h0004

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLB_CLK_PERIOD_NS 20
`define SLB_RST_SEQ_NS    1000
`define SLB_RST_SEQ_CYC   ((`SLB_RST_SEQ_NS + `SLB_CLK_PERIOD_NS - 1) / `SLB_CLK_PERIOD_NS)

`endif

/* File: shared/slb_pkg.sv */
// Types shared by the burst and status interface block
package slb_pkg;

	typedef struct packed {
		logic begin_m;
		logic finish_m;
	} slb_mark_s;

	typedef struct packed {
		logic gap;
		logic fatal;
		logic fixed;
		logic ovf;
	} slb_err_s;

	typedef enum logic [1:0] {
		SLB_RST_HOLD,
		SLB_RST_SEQ,
		SLB_RST_DONE
	} slb_rst_e;

endpackage

/* File: core/slb_adapt_fifo.sv */
// Source adaptation FIFO with duplicated storage for upset recovery
`timescale 1ns/1ns
module slb_adapt_fifo #(
	parameter int W     = 66,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic         rd_en,
	input  wire logic         ecc_en,
	input  wire logic         inj_single,
	input  wire logic         inj_double,
	output logic      [W-1:0] rd_data,
	output logic              empty,
	output logic              full,
	output logic              ovf_pulse,
	output logic              fixed_pulse,
	output logic              fatal_pulse
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
			$error("DEPTH must be a power of two of at least 2");
		end
	endgenerate

	// Two copies, each with parity, so one bad copy can be outvoted
	logic [W-1:0] mem_a [DEPTH];
	logic [W-1:0] mem_b [DEPTH];
	logic         par_a [DEPTH];
	logic         par_b [DEPTH];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	logic         ok_a;
	logic         ok_b;
	logic [W-1:0] flip;

	assign flip  = {{(W-1){1'b0}}, 1'b1};
	assign empty = (wp_r == rp_r);
	assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign ok_a  = (^mem_a[rp_r[AW-1:0]]) == par_a[rp_r[AW-1:0]];
	assign ok_b  = (^mem_b[rp_r[AW-1:0]]) == par_b[rp_r[AW-1:0]];
	assign rd_data = (ecc_en && !ok_a) ? mem_b[rp_r[AW-1:0]] : mem_a[rp_r[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (wr_en && !full) begin
			mem_a[wp_r[AW-1:0]] <= wr_data ^ ((inj_single || inj_double) ? flip : '0);
			mem_b[wp_r[AW-1:0]] <= wr_data ^ (inj_double ? flip : '0);
			par_a[wp_r[AW-1:0]] <= ^wr_data;
			par_b[wp_r[AW-1:0]] <= ^wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (wr_en && !full)
				wp_r <= wp_r + 1'b1;
			if (rd_en && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end

	// Upset flags only mean something with ECC on; otherwise held low
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ovf_pulse   <= 1'b0;
			fixed_pulse <= 1'b0;
			fatal_pulse <= 1'b0;
		end else begin
			ovf_pulse   <= wr_en && full;
			fixed_pulse <= ecc_en && rd_en && !empty && !ok_a && ok_b;
			fatal_pulse <= ecc_en && rd_en && !empty && !ok_a && !ok_b;
		end
	end
endmodule

/* File: core/slb_gap_check.sv */
// Idle gap check between a burst finish and the next burst begin
`timescale 1ns/1ns
module slb_gap_check (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        beat,
	input  wire logic        begin_m,
	input  wire logic        finish_m,
	input  wire logic [15:0] gap_cfg,
	output logic             gap_err
);
	logic        open_r;
	logic [15:0] idle_r;

	// Counter saturates so a very long idle still reads as a mismatch
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			open_r  <= 1'b0;
			idle_r  <= '0;
			gap_err <= 1'b0;
		end else begin
			gap_err <= 1'b0;
			if (!enable) begin
				open_r <= 1'b0;
			end else if (beat && (begin_m || finish_m)) begin
				// One-word bursts carry both marks; check before reopening
				if (begin_m && open_r)
					gap_err <= (idle_r != gap_cfg);
				open_r <= finish_m;
				idle_r <= '0;
			end else if (open_r && idle_r != 16'hffff) begin
				idle_r <= idle_r + 16'h0001;
			end
		end
	end
endmodule

/* File: core/slb_top.sv */
// Source burst and error status, sink clocks and resets, register port
//------------------------------------------------------------------
// Summary of operation
// - Four-bit source error, bit0 FIFO overflow
// - Bit1: upset corrected, ECC on only
// - Bit2: upset uncorrectable, ECC on only
// - Bit3: burst gap differs from configuration
// - Standard clocking drives sink user clock
// - Sink user reset follows core reset, sequence
// - Advanced clocking drives sink interface clock
//------------------------------------------------------------------
`timescale 1ns/1ns
`include "slb_map.svh"
module slb_top #(
	parameter int LANES      = 1,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire logic                  core_reset,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	input  wire logic                  src_valid,
	input  wire logic [64*LANES-1:0]   src_data,
	input  wire logic                  src_burst_begin,
	input  wire logic                  src_burst_finish,
	output logic      [3:0]            src_error,
	input  wire logic                  lane_ready,
	output logic                       lane_valid,
	output logic      [64*LANES-1:0]   lane_data,
	output logic                       lane_begin,
	output logic                       lane_finish,
	output logic                       sink_user_clk,
	output logic                       sink_user_clk_reset,
	output logic                       sink_if_clk,
	output logic                       sink_if_clk_reset,
	output logic                       irq
);
	localparam int DW = 64 * LANES;
	localparam int FW = DW + 2;
	localparam logic [15:0] SEQ_CYC = 16'(`SLB_RST_SEQ_CYC);

	generate
		if (LANES < 1 || LANES > 24) begin : g_chk
			$error("LANES must lie between 1 and 24");
		end
	endgenerate

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	//--------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------
	logic [4:0]       ctrl_r;
	logic [15:0]      gap_r;
	logic [3:0]       mask_r;
	logic [3:0]       status_r;
	logic [3:0]       status_nxt;
	logic [31:0]      errcnt_r;
	logic             burst_mode;
	logic             adv_clk;
	logic             ecc_en;

	assign burst_mode = ctrl_r[`SLB_CTRL_BURST];
	assign adv_clk    = ctrl_r[`SLB_CTRL_ADVCLK];
	assign ecc_en     = ctrl_r[`SLB_CTRL_ECC];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= `SLB_CTRL_RST_VAL;
			gap_r  <= `SLB_GAP_RST_VAL;
			mask_r <= 4'h0;
		end else if (reg_wr) begin
			if (hit(reg_addr, `SLB_OFS_CTRL))
				ctrl_r <= reg_wdata[4:0];
			if (hit(reg_addr, `SLB_OFS_GAP))
				gap_r <= reg_wdata[15:0];
			if (hit(reg_addr, `SLB_OFS_MASK))
				mask_r <= reg_wdata[3:0];
		end else begin
			// Injection bits are one-shot so a single write corrupts one word
			if (src_valid) begin
				ctrl_r[`SLB_CTRL_INJ1] <= 1'b0;
				ctrl_r[`SLB_CTRL_INJ2] <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// Core reset synchroniser and reset sequence
	//--------------------------------------------------------------
	logic                   crst_m_r;
	logic                   crst_s_r;
	logic [15:0]            seq_r;
	slb_pkg::slb_rst_e      rst_st_r;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			crst_m_r <= 1'b1;
			crst_s_r <= 1'b1;
		end else begin
			crst_m_r <= core_reset;
			crst_s_r <= crst_m_r;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_st_r <= slb_pkg::SLB_RST_HOLD;
			seq_r    <= '0;
		end else if (crst_s_r) begin
			rst_st_r <= slb_pkg::SLB_RST_HOLD;
			seq_r    <= '0;
		end else begin
			case (rst_st_r)
				slb_pkg::SLB_RST_HOLD: begin
					rst_st_r <= slb_pkg::SLB_RST_SEQ;
				end
				slb_pkg::SLB_RST_SEQ: begin
					seq_r <= seq_r + 16'h0001;
					if (seq_r == SEQ_CYC - 16'h0001)
						rst_st_r <= slb_pkg::SLB_RST_DONE;
				end
				slb_pkg::SLB_RST_DONE: begin
					rst_st_r <= slb_pkg::SLB_RST_DONE;
				end
				default: begin
					rst_st_r <= slb_pkg::SLB_RST_HOLD;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Sink clocks and resets
	//--------------------------------------------------------------
	// Clocks are half rate toggles; only the active mode's clock runs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sink_user_clk <= 1'b0;
			sink_if_clk   <= 1'b0;
		end else begin
			sink_user_clk <= !adv_clk && !sink_user_clk;
			sink_if_clk   <= adv_clk && !sink_if_clk;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sink_user_clk_reset <= 1'b1;
			sink_if_clk_reset   <= 1'b1;
		end else begin
			sink_user_clk_reset <= rst_st_r != slb_pkg::SLB_RST_DONE;
			sink_if_clk_reset   <= rst_st_r != slb_pkg::SLB_RST_DONE;
		end
	end

	//--------------------------------------------------------------
	// Source path through the adaptation FIFO
	//--------------------------------------------------------------
	logic [FW-1:0]  fifo_out;
	logic           fifo_empty;
	logic           fifo_full;
	logic           fifo_pop;
	logic           ovf_p;
	logic           fixed_p;
	logic           fatal_p;
	logic           gap_p;
	logic           src_beat;
	logic           link_up;

	// Words offered before the sequence completes are not taken
	assign link_up  = (rst_st_r == slb_pkg::SLB_RST_DONE);
	assign src_beat = src_valid && link_up;
	assign fifo_pop = !fifo_empty && (lane_ready || !lane_valid);

	slb_adapt_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.wr_en       (src_beat),
		.wr_data     ({src_burst_begin, src_burst_finish, src_data}),
		.rd_en       (fifo_pop),
		.ecc_en      (ecc_en),
		.inj_single  (ctrl_r[`SLB_CTRL_INJ1]),
		.inj_double  (ctrl_r[`SLB_CTRL_INJ2]),
		.rd_data     (fifo_out),
		.empty       (fifo_empty),
		.full        (fifo_full),
		.ovf_pulse   (ovf_p),
		.fixed_pulse (fixed_p),
		.fatal_pulse (fatal_p)
	);

	// Finish markers are only meaningful in burst mode
	slb_gap_check u_gap (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.enable   (burst_mode),
		.beat     (src_beat),
		.begin_m  (src_burst_begin),
		.finish_m (src_burst_finish),
		.gap_cfg  (gap_r),
		.gap_err  (gap_p)
	);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lane_valid  <= 1'b0;
			lane_data   <= '0;
			lane_begin  <= 1'b0;
			lane_finish <= 1'b0;
		end else if (fifo_pop) begin
			lane_valid  <= 1'b1;
			lane_data   <= fifo_out[DW-1:0];
			lane_begin  <= fifo_out[DW+1];
			lane_finish <= fifo_out[DW];
		end else if (lane_ready) begin
			lane_valid  <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Error vector, status, mask and interrupt
	//--------------------------------------------------------------
	slb_pkg::slb_err_s ev;

	assign ev = '{gap: gap_p, fatal: fatal_p, fixed: fixed_p, ovf: ovf_p};

	// Registered copy of the one-cycle events, so each stands a full cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			src_error <= 4'h0;
		else
			src_error <= ev;
	end

	// Set wins over a write-one clear in the same cycle
	always_comb begin
		status_nxt = status_r;
		if (reg_wr && hit(reg_addr, `SLB_OFS_STATUS))
			status_nxt = status_nxt & ~reg_wdata[3:0];
		status_nxt = status_nxt | ev;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status_r <= 4'h0;
			irq      <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq      <= |(status_nxt & mask_r);
		end
	end

	// Saturating per-kind counters for field diagnostics
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cnt
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn)
					errcnt_r[8*gi +: 8] <= 8'h00;
				else if (reg_wr && hit(reg_addr, `SLB_OFS_ERRCNT))
					errcnt_r[8*gi +: 8] <= 8'h00;
				else if (ev[gi] && errcnt_r[8*gi +: 8] != 8'hff)
					errcnt_r[8*gi +: 8] <= errcnt_r[8*gi +: 8] + 8'h01;
			end
		end
	endgenerate

	//--------------------------------------------------------------
	// Read port
	//--------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`SLB_OFS_CTRL:   reg_rdata <= {27'h0, ctrl_r};
				`SLB_OFS_STATUS: reg_rdata <= {28'h0, status_r};
				`SLB_OFS_MASK:   reg_rdata <= {28'h0, mask_r};
				`SLB_OFS_STATE:  reg_rdata <= {26'h0, rst_st_r, link_up,
					fifo_full, fifo_empty, lane_valid};
				`SLB_OFS_GAP:    reg_rdata <= {16'h0, gap_r};
				`SLB_OFS_ERRCNT: reg_rdata <= errcnt_r;
				default:         reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

/* File: verification/slb_top_chk.sv */
// Port-level assertions for the burst and status block
`timescale 1ns/1ns
module slb_top_chk (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        core_reset,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        src_valid,
	input wire logic        src_burst_begin,
	input wire logic [3:0]  src_error,
	input wire logic        sink_user_clk,
	input wire logic        sink_user_clk_reset,
	input wire logic        sink_if_clk,
	input wire logic        sink_if_clk_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic [6:0] seq_r;
	wire        beat_begin = src_valid & src_burst_begin;
	// Sequence length counter; saturates so a stuck reset cannot wrap
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			seq_r <= 7'h00;
		else if (core_reset || !sink_user_clk_reset)
			seq_r <= 7'h00;
		else if (seq_r != 7'h7f)
			seq_r <= seq_r + 7'h01;
	end
	sequence s_core_held;
		core_reset [*5];
	endsequence
	sequence s_rst_drop;
		$fell(sink_user_clk_reset);
	endsequence
	property p_uclk_half;
		sink_user_clk |=> !sink_user_clk;
	endproperty
	a_uclk_half: assert property (p_uclk_half) else $error("user clock not halved");
	property p_ifclk_half;
		sink_if_clk |=> !sink_if_clk;
	endproperty
	a_ifclk_half: assert property (p_ifclk_half) else $error("if clock not halved");
	property p_clk_excl;
		!(sink_user_clk && sink_if_clk);
	endproperty
	a_clk_excl: assert property (p_clk_excl) else $error("both sink clocks");
	property p_clk_run;
		!sink_user_clk && !sink_if_clk |=> sink_user_clk || sink_if_clk;
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("sink clock stalled");
	property p_rst_hold;
		s_core_held |=> sink_user_clk_reset && sink_if_clk_reset;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("sink reset low");
	property p_rst_len;
		s_rst_drop |-> seq_r >= 7'h32;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset sequence short");
	property p_rst_max;
		seq_r <= 7'h3c;
	endproperty
	a_rst_max: assert property (p_rst_max) else $error("reset sequence long");
	property p_gap_cause;
		$rose(src_error[3]) |-> $past(beat_begin, 2) || $past(beat_begin, 3);
	endproperty
	a_gap_cause: assert property (p_gap_cause) else $error("gap flag no begin");
	property p_ovf_cause;
		$rose(src_error[0]) |-> $past(src_valid, 2) || $past(src_valid, 3);
	endproperty
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow no write");
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data stands");
endmodule
bind slb_top slb_top_chk i_chk (
	.clk_sys(clk_sys), .resetn(resetn), .core_reset(core_reset), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .src_valid(src_valid), .src_burst_begin(src_burst_begin),
	.src_error(src_error), .sink_user_clk(sink_user_clk),
	.sink_user_clk_reset(sink_user_clk_reset), .sink_if_clk(sink_if_clk),
	.sink_if_clk_reset(sink_if_clk_reset)
);

/* File: verification/slb_user_model.sv */
// User logic on both stream sides: source feeder and lane consumer
`timescale 1ns/1ns
module slb_user_model (
	input  wire logic        clk_sys,
	input  wire logic        link_down,
	output logic             src_valid = 1'b0,
	output logic      [63:0] src_data = 64'h0,
	output logic             src_burst_begin = 1'b0,
	output logic             src_burst_finish = 1'b0,
	output logic             lane_ready = 1'b1,
	input  wire logic        lane_valid,
	input  wire logic [63:0] lane_data
);
	logic [63:0] got[$];
	logic        stall = 1'b0;
	// Stall halves the drain rate, enough to overrun the FIFO
	always @(posedge clk_sys) lane_ready <= stall ? ~lane_ready : 1'b1;
	// Words seen while the link is down are not data
	always @(posedge clk_sys) if (lane_valid && lane_ready && !link_down) got.push_back(lane_data);
	task automatic burst(input int n, input logic [63:0] base, input logic beg, input logic fin);
		for (int i = 0; i < n; i++) begin
			src_valid <= 1'b1;
			src_data <= base + 64'(i);
			src_burst_begin <= beg && (i == 0);
			src_burst_finish <= fin && (i == n - 1);
			@(posedge clk_sys);
		end
		src_valid <= 1'b0;
		src_burst_begin <= 1'b0;
		src_burst_finish <= 1'b0;
		src_data <= ~src_data;
	endtask
endmodule

/* File: verification/slb_top_tb.sv */
// Self-checking bench for the burst and status block
`timescale 1ns/1ns
`include "slb_map.svh"
module slb_top_tb;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        core_reset = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        src_valid, src_burst_begin, src_burst_finish, lane_ready, lane_valid;
	logic [63:0] src_data, lane_data;
	logic [3:0]  src_error;
	logic [3:0]  seen_r = 4'h0;
	logic        seen_clr = 1'b0;
	logic        sink_user_clk, sink_user_clk_reset, sink_if_clk, sink_if_clk_reset, irq;
	logic        lane_begin, lane_finish;
	int          n_beg = 0;
	int          n_fin = 0;
	int          n_acc = 0;
	logic [31:0] ctl[4] = '{32'hc, 32'h14, 32'h8, 32'h10};
	logic [31:0] ecc_exp[4] = '{32'h2, 32'h4, 32'h0, 32'h0};
	int          gaps[3] = '{4, 3, 5};
	int          fails = 0;
	int          compares = 0;
	int          cycles = 0;
	int          n;
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) seen_r <= seen_clr ? 4'h0 : (seen_r | src_error);
	// Every word taken on the lane side, with its markers
	always @(posedge clk_sys) begin
		if (lane_valid && lane_ready) begin
			n_acc++;
			n_beg += int'(lane_begin);
			n_fin += int'(lane_finish);
		end
	end
	slb_top #(.LANES(1), .FIFO_DEPTH(8)) i_dut (
		.clk_sys(clk_sys), .resetn(resetn), .core_reset(core_reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_valid(src_valid), .src_data(src_data), .src_burst_begin(src_burst_begin),
		.src_burst_finish(src_burst_finish), .src_error(src_error), .lane_ready(lane_ready),
		.lane_valid(lane_valid), .lane_data(lane_data), .lane_begin(lane_begin),
		.lane_finish(lane_finish),
		.sink_user_clk(sink_user_clk), .sink_user_clk_reset(sink_user_clk_reset),
		.sink_if_clk(sink_if_clk), .sink_if_clk_reset(sink_if_clk_reset), .irq(irq)
	);
	slb_user_model i_user (
		.clk_sys(clk_sys), .link_down(sink_user_clk_reset), .src_valid(src_valid),
		.src_data(src_data), .src_burst_begin(src_burst_begin),
		.src_burst_finish(src_burst_finish), .lane_ready(lane_ready),
		.lane_valid(lane_valid), .lane_data(lane_data)
	);
	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic clear_seen();
		seen_clr <= 1'b1;
		@(posedge clk_sys);
		seen_clr <= 1'b0;
	endtask
	task automatic await_link();
		n = 0;
		while (sink_user_clk_reset !== 1'b0 && n < 80) begin
			@(posedge clk_sys);
			#1 n++;
		end
		check(32'(n >= 50 && n <= 60), 32'h1);
	endtask
	task automatic clk_count(input int eu, input int ei);
		int cu, ci;
		cu = 0;
		ci = 0;
		repeat (8) begin
			@(posedge clk_sys);
			#1 cu += int'(sink_user_clk === 1'b1);
			ci += int'(sink_if_clk === 1'b1);
		end
		check(cu, eu);
		check(ci, ei);
	endtask
	task automatic summarize();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard well above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			summarize();
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		await_link();
		rd(`SLB_OFS_CTRL, 32'h0);
		rd(`SLB_OFS_STATE, 32'h2a);
		rd(`SLB_OFS_GAP, {16'h0, `SLB_GAP_RST_VAL});
		rd(8'h18, 32'h0);
		clk_count(4, 0);
		@(posedge clk_sys);
		i_user.burst(5, 64'h100, 1'b1, 1'b0);
		repeat (6) @(posedge clk_sys);
		check(i_user.got.size(), 5);
		for (int i = 0; i < 5; i++) check(i_user.got[i][31:0], 32'h100 + i);
		i_user.stall <= 1'b1;
		clear_seen();
		i_user.burst(24, 64'h200, 1'b0, 1'b0);
		i_user.stall <= 1'b0;
		repeat (12) @(posedge clk_sys);
		check({28'h0, seen_r}, 32'h1);
		rd(`SLB_OFS_STATUS, 32'h1);
		check({31'h0, irq}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(`SLB_OFS_CTRL, ctl[k]);
			clear_seen();
			i_user.burst(2, 64'h300, 1'b0, 1'b0);
			repeat (10) @(posedge clk_sys);
			check({28'h0, seen_r}, ecc_exp[k]);
		end
		wr(`SLB_OFS_CTRL, 32'h2);
		clk_count(0, 4);
		wr(`SLB_OFS_CTRL, 32'h1);
		wr(`SLB_OFS_MASK, 32'h8);
		i_user.burst(4, 64'h400, 1'b1, 1'b1);
		wr(`SLB_OFS_ERRCNT, 32'h0);
		repeat (2) @(posedge clk_sys);
		foreach (gaps[g]) begin
			i_user.burst(4, 64'h500, 1'b1, 1'b1);
			repeat (gaps[g]) @(posedge clk_sys);
		end
		i_user.burst(4, 64'h600, 1'b1, 1'b1);
		repeat (8) @(posedge clk_sys);
		rd(`SLB_OFS_ERRCNT, 32'h02000000);
		check(n_beg, 6);
		check(n_fin, 5);
		check({31'h0, irq}, 32'h1);
		wr(`SLB_OFS_STATUS, 32'hf);
		rd(`SLB_OFS_STATUS, 32'h0);
		check({31'h0, irq}, 32'h0);
		@(posedge clk_sys);
		core_reset <= 1'b1;
		repeat (5) @(posedge clk_sys);
		// Words offered while the link is down must never reach the lane side
		n = n_acc;
		i_user.burst(2, 64'h700, 1'b0, 1'b0);
		rd(`SLB_OFS_STATE, 32'h2);
		check(n_acc, n);
		check({31'h0, sink_user_clk_reset}, 32'h1);
		check({31'h0, sink_if_clk_reset}, 32'h1);
		@(posedge clk_sys);
		core_reset <= 1'b0;
		await_link();
		check({31'h0, sink_if_clk_reset}, 32'h0);
		summarize();
	end
endmodule
